// ### inc/uie_pkg.sv
// Shared constants and carrier types for the interrupt-mask and enhanced register block.
// Assumes one UART channel behind a 3-bit parallel register address.
package uie_pkg;

  // ==========================================================================
  // Sizes
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned CHAR_W     = 8;

  // ==========================================================================
  // Register addresses, normal bank
  localparam logic [2:0] A_DATA  = 3'h0;
  localparam logic [2:0] A_IMASK = 3'h1;
  localparam logic [2:0] A_ISR   = 3'h2;
  localparam logic [2:0] A_LCR   = 3'h3;
  localparam logic [2:0] A_LSR   = 3'h5;
  localparam logic [2:0] A_MSR   = 3'h6;
  // Enhanced bank
  localparam logic [2:0] A_EFR   = 3'h2;
  localparam logic [2:0] A_RES1  = 3'h4;
  localparam logic [2:0] A_RES2  = 3'h5;
  localparam logic [2:0] A_PAU1  = 3'h6;
  localparam logic [2:0] A_PAU2  = 3'h7;

  // ==========================================================================
  // Keys, reset values and field positions
  localparam logic [7:0] LCR_ENH_KEY = 8'hBF;
  localparam logic [7:0] REG_RST     = 8'h00;
  localparam int LCR_BANK  = 7;
  localparam int EFR_ENH   = 4;
  localparam int EFR_RXFC0 = 0;
  localparam int EFR_RXFC1 = 1;
  localparam int FCR_EN    = 0;
  localparam int FCR_RXRST = 1;
  localparam int FCR_TXRST = 2;
  localparam int FCR_TXT   = 4;
  localparam int FCR_RXT   = 6;
  localparam int IM_RX     = 0;
  localparam int IM_TX     = 1;
  localparam int IM_LS     = 2;
  localparam int IM_MS     = 3;
  localparam int IM_SLEEP  = 4;
  localparam int IM_XOFF   = 5;
  localparam int IM_RTS    = 6;
  localparam int IM_CTS    = 7;

  // ==========================================================================
  // Trigger levels and interrupt source codes
  localparam logic [4:0] TRIG_L0 = 5'h01;
  localparam logic [4:0] TRIG_L1 = 5'h04;
  localparam logic [4:0] TRIG_L2 = 5'h08;
  localparam logic [4:0] TRIG_L3 = 5'h0E;
  localparam logic [5:0] ISR_LS   = 6'h06;
  localparam logic [5:0] ISR_RX   = 6'h04;
  localparam logic [5:0] ISR_TX   = 6'h02;
  localparam logic [5:0] ISR_MS   = 6'h00;
  localparam logic [5:0] ISR_XOFF = 6'h10;
  localparam logic [5:0] ISR_FLOW = 6'h20;
  localparam logic [5:0] ISR_NONE = 6'h01;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic              brk;
    logic              frm;
    logic              par;
    logic [CHAR_W-1:0] data;
  } uie_rx_word_t;

  typedef struct packed {
    logic [CHAR_W-1:0] pause2;
    logic [CHAR_W-1:0] pause1;
    logic [CHAR_W-1:0] resume2;
    logic [CHAR_W-1:0] resume1;
  } uie_flow_chars_t;

endpackage

// ### src/uie_fifo.sv
// Flip-flop FIFO with valid/ready on both sides and a synchronous flush.
// Assumes a power-of-two depth so the pointers wrap by themselves.
`timescale 1ns/1ps
module uie_fifo #(
  parameter int unsigned WIDTH = 11,
  parameter int unsigned DEPTH = 16,
  localparam int unsigned CW   = $clog2(DEPTH + 1),
  localparam int unsigned AW   = $clog2(DEPTH)
) (
  input  wire logic             i_clk,
  input  wire logic             i_arst_n,
  input  wire logic             i_flush,
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic      [WIDTH-1:0] o_data,
  output logic      [CW-1:0]    o_count
);
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("uie_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [CW-1:0]    cnt_q;

  wire push = i_valid & o_ready & ~i_flush;
  wire pop  = o_valid & i_ready & ~i_flush;

  assign o_ready = (cnt_q != CW'(DEPTH));
  assign o_valid = (cnt_q != '0);
  assign o_data  = mem_q[rd_q];
  assign o_count = cnt_q;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_q] <= i_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (i_flush) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_q + AW'(push);
      rd_q  <= rd_q + AW'(pop);
      cnt_q <= cnt_q + CW'(push) - CW'(pop);
    end
  end
endmodule // uie_fifo

// ### src/uie_sync.sv
// Two-stage synchroniser for levels arriving from pins.
// Assumes the destination runs on i_clk.
`timescale 1ns/1ps
module uie_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_arst_n,
  input  wire logic [WIDTH-1:0] i_d,
  output logic      [WIDTH-1:0] o_q
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_q <= '0;
      o_q    <= '0;
    end else begin
      meta_q <= i_d;
      o_q    <= meta_q;
    end
  end
endmodule // uie_sync

// ### src/uie_top.sv
// Interrupt mask, enhanced feature and flow-character registers of one UART channel,
// with receive FIFO, line status and interrupt source reporting.
// Assumes bus strobes are synchronous one-cycle pulses on i_clk; CTS# comes from a pin.
`timescale 1ns/1ps

// Operation
// - Enhanced mask bits 4-7 take effect only while enhanced-feature bit 4 is set.
// - Interrupt mask gates rx, tx, line and modem sources; status reports them.
// - FIFO mode: rx interrupt while fill is at or above trigger level.
// - Status source shows rx trigger and drops with fill below trigger.
// - Data-ready line bit set on each stored char, cleared when FIFO empty.
// - FIFOs on with mask bits 0-3 clear means polled mode via line status.
// - Line status bit 1 flags receive overrun.
// - Line status bits 2-4 show errors of the head character.
// - Bit 5 means holding empty; bit 6 means FIFO and shifter empty.
// - Bit 7 set while any stored character carries an error.
// - Mask bit 0 enables rx data interrupt; resets to zero.
// - Mask bit 1 enables transmit ready interrupt; resets to zero.
// - Enabling mask bit 1 with holding empty raises transmit ready at once.
// - Mask bit 2 enables line interrupt from line status bits 1-4.
// - Overrun interrupts on arrival; other errors when read out.
// - Mask bit 3 gates modem interrupt; resets to zero.
// - Mask bit 4 allows sleep; writable only in enhanced mode.
// - Mask bit 5 gates received pause interrupt; enhanced only.
// - Mask bit 6 interrupts on own RTS# rising; enhanced only.
// - Mask bit 7 interrupts on CTS# rising; enhanced only.
// - Status read or holding write clears pending transmit ready.
// - Line status read clears pending line interrupt.
module uie_top #(
  parameter int unsigned DEPTH = uie_pkg::FIFO_DEPTH,
  localparam int unsigned CW   = $clog2(DEPTH + 1)
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_arst_n,
  input  wire logic                     i_cs,
  input  wire logic                     i_rd,
  input  wire logic                     i_wr,
  input  wire logic [2:0]               i_addr,
  input  wire logic [7:0]               i_wdata,
  output logic      [7:0]               o_rdata,
  input  wire logic                     i_rx_valid,
  input  wire uie_pkg::uie_rx_word_t    i_rx_word,
  output logic                          o_rx_ready,
  input  wire logic                     i_tx_pop,
  input  wire logic                     i_tsr_empty,
  output logic                          o_tx_valid,
  output logic      [7:0]               o_tx_data,
  input  wire logic                     i_rts_n,
  input  wire logic                     i_cts_n,
  input  wire logic [7:0]               i_msr_data,
  input  wire logic                     i_msr_int,
  output logic                          o_irq,
  output logic                          o_enh_en,
  output logic                          o_sleep_en,
  output logic                          o_fifo_en,
  output logic                          o_polled,
  output logic                          o_tx_paused,
  output uie_pkg::uie_flow_chars_t      o_flow_chars
);
  import uie_pkg::*;

  if (DEPTH < 16 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("uie_top: DEPTH must be a power of two of at least 16");
  end

  // ==========================================================================
  // Functions
  function automatic logic hit(input logic [2:0] a, input logic [2:0] r, input logic bank);
    hit = bank & (a == r);
  endfunction

  function automatic logic [CW-1:0] trig(input logic [1:0] sel);
    trig = (sel == 2'h0) ? CW'(TRIG_L0) : (sel == 2'h1) ? CW'(TRIG_L1) :
           (sel == 2'h2) ? CW'(TRIG_L2) : CW'(TRIG_L3);
  endfunction

  function automatic logic [5:0] code(input logic ls, input logic rx, input logic tx,
                                      input logic ms, input logic xo, input logic fl);
    code = ls ? ISR_LS : rx ? ISR_RX : tx ? ISR_TX : ms ? ISR_MS :
           xo ? ISR_XOFF : fl ? ISR_FLOW : ISR_NONE;
  endfunction

  // ==========================================================================
  // State
  logic [7:0]    lcr_q, imask_q, efr_q, res1_q, res2_q, pau1_q, pau2_q;
  logic          fifo_en_q;
  logic [1:0]    rxt_q, txt_q;
  logic [CW-1:0] tx_cnt_q, err_cnt_q;
  logic          ovr_q, lsp_q, txp_q, xop_q, flp_q, txc_q, rts_n_q, cts_p_q;
  logic          cts_s;
  uie_rx_word_t  rx_head;
  logic          rx_out_valid, rx_rdy_unused;
  logic [CW-1:0] rx_cnt;

  // ==========================================================================
  // Address decode
  wire acc_rd  = i_cs & i_rd;
  wire acc_wr  = i_cs & i_wr;
  wire enh_map = (lcr_q == LCR_ENH_KEY);
  wire norm    = ~lcr_q[LCR_BANK];
  wire enh     = efr_q[EFR_ENH];
  wire wr_lcr  = acc_wr & (i_addr == A_LCR);
  wire wr_thr  = acc_wr & hit(i_addr, A_DATA, norm);
  wire rd_rhr  = acc_rd & hit(i_addr, A_DATA, norm);
  wire wr_im   = acc_wr & hit(i_addr, A_IMASK, norm);
  wire rd_isr  = acc_rd & hit(i_addr, A_ISR, norm);
  wire wr_fcr  = acc_wr & hit(i_addr, A_ISR, norm);
  wire rd_lsr  = acc_rd & hit(i_addr, A_LSR, norm);
  wire rd_msr  = acc_rd & hit(i_addr, A_MSR, norm);
  wire wr_efr  = acc_wr & hit(i_addr, A_EFR, enh_map);
  wire wr_res1 = acc_wr & hit(i_addr, A_RES1, enh_map);
  wire wr_res2 = acc_wr & hit(i_addr, A_RES2, enh_map);
  wire wr_pau1 = acc_wr & hit(i_addr, A_PAU1, enh_map);
  wire wr_pau2 = acc_wr & hit(i_addr, A_PAU2, enh_map);

  // ==========================================================================
  // Control registers
  // upper mask bits written only in enhanced mode
  wire [7:0] imask_d = enh ? i_wdata : {imask_q[7:4], i_wdata[3:0]};
  wire       fcr_go  = wr_fcr & i_wdata[FCR_EN];
  wire       rx_fl   = (fcr_go & i_wdata[FCR_RXRST]) | (wr_fcr & (i_wdata[FCR_EN] != fifo_en_q));
  wire       tx_fl   = (fcr_go & i_wdata[FCR_TXRST]) | (wr_fcr & (i_wdata[FCR_EN] != fifo_en_q));

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lcr_q     <= REG_RST;
      imask_q   <= REG_RST;
      efr_q     <= REG_RST;
      fifo_en_q <= 1'b0;
      rxt_q     <= 2'h0;
      txt_q     <= 2'h0;
    end else begin
      if (wr_lcr) lcr_q <= i_wdata;
      if (wr_im) imask_q <= imask_d;
      if (wr_efr) efr_q <= i_wdata;
      if (wr_fcr) fifo_en_q <= i_wdata[FCR_EN];
      if (fcr_go) rxt_q <= i_wdata[FCR_RXT+1:FCR_RXT];
      // transmit trigger select needs enhanced mode
      if (fcr_go && enh) txt_q <= i_wdata[FCR_TXT+1:FCR_TXT];
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      res1_q <= REG_RST;
      res2_q <= REG_RST;
      pau1_q <= REG_RST;
      pau2_q <= REG_RST;
    end else begin
      if (wr_res1) res1_q <= i_wdata;
      if (wr_res2) res2_q <= i_wdata;
      if (wr_pau1) pau1_q <= i_wdata;
      if (wr_pau2) pau2_q <= i_wdata;
    end
  end

  // ==========================================================================
  // Receive FIFO
  wire [CW-1:0] rx_lim    = fifo_en_q ? CW'(DEPTH) : CW'(1);
  wire          rx_push   = i_rx_valid & o_rx_ready;
  wire          rx_pop    = rd_rhr & rx_out_valid;
  wire          ovr_evt   = i_rx_valid & ~o_rx_ready;
  wire          push_err  = rx_push & (i_rx_word.brk | i_rx_word.frm | i_rx_word.par);
  wire          pop_err   = rx_pop & (rx_head.brk | rx_head.frm | rx_head.par);
  wire [CW-1:0] rx_cnt_nx = rx_fl ? '0 : rx_cnt + CW'(rx_push) - CW'(rx_pop);

  uie_fifo #(
    .WIDTH ($bits(uie_rx_word_t)),
    .DEPTH (DEPTH)
  ) u_rx_fifo (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_flush  (rx_fl),
    .i_valid  (rx_push),
    .o_ready  (rx_rdy_unused),
    .i_data   (i_rx_word),
    .o_valid  (rx_out_valid),
    .i_ready  (rd_rhr),
    .o_data   (rx_head),
    .o_count  (rx_cnt)
  );

  // ==========================================================================
  // Transmit holding count
  wire [CW-1:0] tx_lim     = fifo_en_q ? CW'(DEPTH) : CW'(1);
  wire          tx_take    = wr_thr & (tx_cnt_q < tx_lim);
  wire          tx_dec     = i_tx_pop & (tx_cnt_q != '0);
  wire          thr_empty  = (tx_cnt_q == '0);
  wire          tx_cond    = fifo_en_q ? (tx_cnt_q < trig(txt_q)) : thr_empty;
  // immediate event on enabling with holding empty
  wire          tx_arm     = wr_im & i_wdata[IM_TX] & ~imask_q[IM_TX] & thr_empty;
  wire          tx_set     = (tx_cond & ~txc_q) | tx_arm;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tx_cnt_q   <= '0;
      o_tx_valid <= 1'b0;
      o_tx_data  <= REG_RST;
    end else begin
      tx_cnt_q   <= tx_fl ? '0 : tx_cnt_q + CW'(tx_take) - CW'(tx_dec);
      o_tx_valid <= tx_take;
      o_tx_data  <= i_wdata;
    end
  end

  // ==========================================================================
  // Line status
  // line status byte
  wire [7:0] lsr_val = {(err_cnt_q != '0), thr_empty & i_tsr_empty, thr_empty,
                        rx_out_valid & rx_head.brk, rx_out_valid & rx_head.frm,
                        rx_out_valid & rx_head.par, ovr_q, rx_out_valid};
  // overrun at once, other errors on read-out
  wire       ls_set  = ovr_evt | pop_err;
  wire       fc_rx   = efr_q[EFR_RXFC0] | efr_q[EFR_RXFC1];
  wire       xo_hit  = rx_push & fc_rx & ((i_rx_word.data == pau1_q) | (i_rx_word.data == pau2_q));
  wire       xn_hit  = rx_push & fc_rx & ((i_rx_word.data == res1_q) | (i_rx_word.data == res2_q));
  wire       rts_up  = i_rts_n & ~rts_n_q;
  wire       cts_up  = ~cts_s & cts_p_q;
  wire       en_xo   = imask_q[IM_XOFF] & enh;
  wire       en_rts  = imask_q[IM_RTS] & enh;
  wire       en_cts  = imask_q[IM_CTS] & enh;
  wire       fl_set  = (rts_up & en_rts) | (cts_up & en_cts);

  uie_sync #(
    .WIDTH (1)
  ) u_cts_sync (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_d      (~i_cts_n),
    .o_q      (cts_s)
  );

  // sticky flags, set wins over clear
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ovr_q     <= 1'b0;
      lsp_q     <= 1'b0;
      txp_q     <= 1'b0;
      xop_q     <= 1'b0;
      flp_q     <= 1'b0;
      txc_q     <= 1'b1;
      rts_n_q   <= 1'b1;
      cts_p_q   <= 1'b0;
      err_cnt_q <= '0;
    end else begin
      ovr_q     <= ovr_evt | (ovr_q & ~rd_lsr);
      lsp_q     <= ls_set | (lsp_q & ~rd_lsr);
      txp_q     <= tx_set | (txp_q & ~(rd_isr | wr_thr));
      xop_q     <= xo_hit | (xop_q & ~(rd_isr | xn_hit));
      flp_q     <= fl_set | (flp_q & ~rd_msr);
      txc_q     <= tx_cond;
      rts_n_q   <= i_rts_n;
      cts_p_q   <= cts_s;
      err_cnt_q <= rx_fl ? '0 : err_cnt_q + CW'(push_err) - CW'(pop_err);
    end
  end

  // ==========================================================================
  // Interrupt sources and status
  // mask gating
  wire       s_ls    = imask_q[IM_LS] & lsp_q;
  wire       s_rx    = imask_q[IM_RX] & (fifo_en_q ? (rx_cnt >= trig(rxt_q)) : rx_out_valid);
  wire       s_tx    = imask_q[IM_TX] & txp_q;
  wire       s_ms    = imask_q[IM_MS] & i_msr_int;
  wire       s_xo    = en_xo & xop_q;
  wire       s_fl    = (en_rts | en_cts) & flp_q;
  wire [7:0] isr_val = {fifo_en_q, fifo_en_q, code(s_ls, s_rx, s_tx, s_ms, s_xo, s_fl)};

  // ==========================================================================
  // Read data select
  wire [7:0] enh_rd  = (i_addr == A_EFR)  ? efr_q  : (i_addr == A_RES1) ? res1_q :
                       (i_addr == A_RES2) ? res2_q : (i_addr == A_PAU1) ? pau1_q :
                       (i_addr == A_PAU2) ? pau2_q : lcr_q;
  wire [7:0] norm_rd = (i_addr == A_DATA)  ? rx_head.data : (i_addr == A_IMASK) ? imask_q :
                       (i_addr == A_ISR)   ? isr_val      : (i_addr == A_LCR)   ? lcr_q :
                       (i_addr == A_LSR)   ? lsr_val      : (i_addr == A_MSR)   ? i_msr_data : REG_RST;
  wire [7:0] rd_mux  = enh_map ? enh_rd : norm ? norm_rd : ((i_addr == A_LCR) ? lcr_q : REG_RST);

  // ==========================================================================
  // Registered outputs
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata      <= REG_RST;
      o_rx_ready   <= 1'b1;
      o_irq        <= 1'b0;
      o_enh_en     <= 1'b0;
      o_sleep_en   <= 1'b0;
      o_fifo_en    <= 1'b0;
      o_polled     <= 1'b0;
      o_tx_paused  <= 1'b0;
      o_flow_chars <= '0;
    end else begin
      if (acc_rd) o_rdata <= rd_mux;
      o_rx_ready   <= (rx_cnt_nx < rx_lim);
      o_irq        <= s_ls | s_rx | s_tx | s_ms | s_xo | s_fl;
      o_enh_en     <= enh;
      // sleep allowed only with enhanced mask bit
      o_sleep_en   <= imask_q[IM_SLEEP] & enh;
      o_fifo_en    <= fifo_en_q;
      o_polled     <= fifo_en_q & (imask_q[3:0] == 4'h0);
      o_tx_paused  <= xo_hit | (o_tx_paused & ~xn_hit);
      o_flow_chars <= '{pause2: pau2_q, pause1: pau1_q, resume2: res2_q, resume1: res1_q};
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  enh_gate_a: assert property (wr_im && !enh |=> imask_q[7:4] == $past(imask_q[7:4]))
    else $error("upper mask bits changed outside enhanced mode");
  efr_map_a: assert property (acc_wr && i_addr == A_EFR && !enh_map |=> efr_q == $past(efr_q))
    else $error("enhanced feature register written without key");
  mask_quiet_a: assert property ((imask_q == 8'h00)[*2] |-> !o_irq)
    else $error("interrupt raised with all sources masked");
  rx_trig_a: assert property (fifo_en_q && imask_q[IM_RX] && rx_cnt >= trig(rxt_q) |=> o_irq)
    else $error("rx trigger reached without interrupt");
  isr_rx_a: assert property (rd_isr && s_rx && !s_ls |=> o_rdata[5:0] == ISR_RX)
    else $error("status did not show rx trigger source");
  data_rdy_a: assert property (rx_push && !rx_fl |=> lsr_val[0])
    else $error("data ready not set after store");
  overrun_a: assert property (ovr_evt |=> lsr_val[1] && lsp_q)
    else $error("overrun not flagged");
  tx_idle_a: assert property (lsr_val[6] |-> lsr_val[5] && i_tsr_empty)
    else $error("idle flag without empty holding");
  gerr_a: assert property (push_err && !rx_fl |=> lsr_val[7])
    else $error("global error flag missing");
  tx_imm_a: assert property (tx_arm && !rd_isr |=> txp_q ##1 o_irq)
    else $error("no immediate transmit ready interrupt");
  ls_clear_a: assert property (rd_lsr && !ls_set |=> !lsp_q && !ovr_q)
    else $error("line interrupt not cleared by status read");
  tx_clear_a: assert property ((rd_isr || wr_thr) && !tx_set |=> !txp_q)
    else $error("transmit ready not cleared");
  cts_int_a: assert property (cts_up && en_cts |=> flp_q)
    else $error("CTS rising edge missed");
  sleep_gate_a: assert property (o_sleep_en |-> $past(imask_q[IM_SLEEP] && enh))
    else $error("sleep enabled without enhanced mask bit");

  cov_overrun: cover property (ovr_evt ##1 rd_lsr);
  cov_rx_trig: cover property (fifo_en_q && rx_cnt == trig(rxt_q) && imask_q[IM_RX]);
  cov_pause: cover property (xo_hit ##[1:20] xn_hit);
endmodule // uie_top

// ### tb/tb_uart_interrupt_enable_and_enhanced_regs.sv
// Register-level bench for the interrupt mask and enhanced register block.
// Assumes a 250 MHz clock and the host model driving the bus.
`timescale 1ns/1ps
module tb_uart_interrupt_enable_and_enhanced_regs;
  import uie_pkg::*;
  logic clk, arst_n, cs, rd, wr, rxv, rxr, txv, irq, enh, slp, fen, pol, pau, rts_n, cts_n, msr_int, tx_pop, tsr_e;
  logic [2:0] addr;
  logic [7:0] wd, rdat, txd, r, msd;
  uie_rx_word_t rxw;
  uie_flow_chars_t fc;
  int fail_count, n_compared;
  uie_top uie_top_inst (.i_clk(clk), .i_arst_n(arst_n), .i_cs(cs), .i_rd(rd), .i_wr(wr), .i_addr(addr),
    .i_wdata(wd), .o_rdata(rdat), .i_rx_valid(rxv), .i_rx_word(rxw), .o_rx_ready(rxr), .i_tx_pop(tx_pop),
    .i_tsr_empty(tsr_e), .o_tx_valid(txv), .o_tx_data(txd), .i_rts_n(rts_n), .i_cts_n(cts_n),
    .i_msr_data(msd), .i_msr_int(msr_int), .o_irq(irq), .o_enh_en(enh), .o_sleep_en(slp),
    .o_fifo_en(fen), .o_polled(pol), .o_tx_paused(pau), .o_flow_chars(fc));
  uie_host_model uie_host_model_inst (.i_clk(clk), .i_rdata(rdat), .o_cs(cs), .o_rd(rd), .o_wr(wr),
    .o_addr(addr), .o_wdata(wd), .o_rx_valid(rxv), .o_rx_word(rxw));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(negedge clk);
    chk({7'h00, irq}, {7'h00, e});
  endtask
  task automatic final_report();
    $display("compared=%0d mismatches=%0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #20000;
    fail_count++;
    final_report();
  end
  initial begin
    {arst_n, rts_n, cts_n, msr_int} = 4'b0110;
    {tx_pop, tsr_e, msd} = {2'b01, 8'h5C};
    fail_count = 0;
    n_compared = 0;
    repeat (5) @(posedge clk);
    @(negedge clk) arst_n = 1'b1;
    uie_host_model_inst.rd(A_IMASK, r); chk(r, REG_RST);
    uie_host_model_inst.rd(A_LSR, r); chk(r, 8'h60);
    uie_host_model_inst.rd(A_ISR, r); chk(r, {2'b00, ISR_NONE});
    uie_host_model_inst.wr(A_LCR, LCR_ENH_KEY);
    uie_host_model_inst.wr(A_EFR, 8'h10);
    for (int i = 4; i < 8; i++) begin
      uie_host_model_inst.wr(3'(i), 8'hA0 + 8'(i));
    end
    for (int i = 4; i < 8; i++) begin
      uie_host_model_inst.rd(3'(i), r); chk(r, 8'hA0 + 8'(i));
    end
    chk(fc[7:0], 8'hA4); chk(fc[31:24], 8'hA7);
    uie_host_model_inst.wr(A_LCR, 8'h03);
    uie_host_model_inst.rd(3'h7, r); chk(r, 8'h00);
    uie_host_model_inst.wr(A_IMASK, 8'h10);
    uie_host_model_inst.rd(A_IMASK, r); chk(r, 8'h10); chk({7'h00, slp}, 8'h01);
    uie_host_model_inst.wr(A_LCR, LCR_ENH_KEY);
    uie_host_model_inst.wr(A_EFR, 8'h00);
    uie_host_model_inst.wr(A_LCR, 8'h03);
    irq_is(1'b0); chk({6'h00, enh, slp}, 8'h00);
    uie_host_model_inst.wr(A_ISR, 8'h41);
    irq_is(1'b0); chk({6'h00, fen, pol}, 8'h03);
    uie_host_model_inst.wr(A_IMASK, 8'h01);
    for (int i = 1; i < 4; i++) begin
      uie_host_model_inst.push(11'(8'h10 + i));
    end
    irq_is(1'b0);
    uie_host_model_inst.rd(A_LSR, r); chk(r, 8'h61);
    uie_host_model_inst.push(11'h014);
    irq_is(1'b1);
    uie_host_model_inst.rd(A_ISR, r); chk(r, {2'b11, ISR_RX});
    uie_host_model_inst.rd(A_DATA, r); chk(r, 8'h11);
    irq_is(1'b0);
    for (int i = 2; i < 5; i++) begin
      uie_host_model_inst.rd(A_DATA, r);
    end
    uie_host_model_inst.rd(A_LSR, r); chk(r, 8'h60);
    uie_host_model_inst.wr(A_IMASK, 8'h04);
    uie_host_model_inst.push(11'h133);
    irq_is(1'b0);
    uie_host_model_inst.rd(A_LSR, r); chk(r, 8'hE5);
    uie_host_model_inst.rd(A_DATA, r); chk(r, 8'h33);
    irq_is(1'b1);
    uie_host_model_inst.rd(A_LSR, r);
    irq_is(1'b0);
    uie_host_model_inst.wr(A_ISR, 8'h00);
    uie_host_model_inst.push(11'h021);
    chk({7'h00, rxr}, 8'h00);
    uie_host_model_inst.push(11'h022);
    irq_is(1'b1);
    uie_host_model_inst.rd(A_LSR, r); chk(r, 8'h63);
    irq_is(1'b0);
    uie_host_model_inst.rd(A_DATA, r); chk(r, 8'h21);
    uie_host_model_inst.wr(A_IMASK, 8'h02);
    irq_is(1'b1);
    uie_host_model_inst.rd(A_ISR, r); chk(r, {2'b00, ISR_TX});
    irq_is(1'b0);
    msr_int = 1'b1;
    uie_host_model_inst.wr(A_IMASK, 8'h08);
    irq_is(1'b1);
    uie_host_model_inst.rd(A_ISR, r); chk(r, {2'b00, ISR_MS});
    msr_int = 1'b0;
    irq_is(1'b0);
    tsr_e = 1'b0;
    uie_host_model_inst.rd(A_LSR, r); chk(r, 8'h20);
    uie_host_model_inst.wr(A_DATA, 8'h5A); chk(txd, 8'h5A); chk({7'h00, txv}, 8'h01);
    uie_host_model_inst.rd(A_LSR, r); chk(r, 8'h00); chk({7'h00, txv}, 8'h00);
    uie_host_model_inst.wr(A_IMASK, 8'h02);
    irq_is(1'b0);
    tx_pop = 1'b1;
    @(negedge clk) tx_pop = 1'b0;
    irq_is(1'b1);
    uie_host_model_inst.wr(A_DATA, 8'hA5);
    irq_is(1'b0);
    uie_host_model_inst.wr(A_LCR, LCR_ENH_KEY);
    uie_host_model_inst.wr(A_EFR, 8'h13);
    uie_host_model_inst.wr(A_LCR, 8'h03);
    uie_host_model_inst.wr(A_IMASK, 8'hE0);
    uie_host_model_inst.push(11'h0A6);
    irq_is(1'b1); chk({7'h00, pau}, 8'h01);
    uie_host_model_inst.rd(A_ISR, r); chk(r, {2'b00, ISR_XOFF});
    uie_host_model_inst.rd(A_DATA, r); chk(r, 8'hA6);
    uie_host_model_inst.push(11'h0A4);
    irq_is(1'b0); chk({7'h00, pau}, 8'h00);
    cts_n = 1'b0;
    irq_is(1'b0);
    cts_n = 1'b1;
    repeat (2) @(negedge clk);
    irq_is(1'b1);
    uie_host_model_inst.rd(A_ISR, r); chk(r, {2'b00, ISR_FLOW});
    uie_host_model_inst.rd(A_MSR, r); chk(r, msd);
    irq_is(1'b0);
    rts_n = 1'b0;
    irq_is(1'b0);
    rts_n = 1'b1;
    irq_is(1'b1);
    final_report();
  end
endmodule // tb_uart_interrupt_enable_and_enhanced_regs

// ### tb/uie_host_model.sv
// Host processor model: register bus strobes and receive character feed.
// Assumes the design samples on the rising clock edge; all driving happens at falling edges.
`timescale 1ns/1ps
module uie_host_model
  import uie_pkg::*;
(
  input  wire logic   i_clk,
  input  wire logic [7:0] i_rdata,
  output logic        o_cs,
  output logic        o_rd,
  output logic        o_wr,
  output logic [2:0]  o_addr,
  output logic [7:0]  o_wdata,
  output logic        o_rx_valid,
  output uie_rx_word_t o_rx_word
);
  initial begin
    {o_cs, o_rd, o_wr, o_rx_valid} = 4'h0;
    o_addr = 3'h0;
    o_wdata = 8'h00;
    o_rx_word = '0;
  end
  // One-cycle write strobe; data inverted once released
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge i_clk);
    {o_cs, o_wr, o_addr, o_wdata} = {2'b11, a, d};
    @(negedge i_clk);
    {o_cs, o_wr, o_wdata} = {2'b00, ~d};
  endtask
  // One-cycle read strobe; data sampled after the taking edge
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge i_clk);
    {o_cs, o_rd, o_addr} = {2'b11, a};
    @(negedge i_clk);
    {o_cs, o_rd} = 2'b00;
    d = i_rdata;
  endtask
  task automatic push(input uie_rx_word_t w);
    @(negedge i_clk);
    {o_rx_valid, o_rx_word} = {1'b1, w};
    @(negedge i_clk);
    {o_rx_valid, o_rx_word} = {1'b0, ~w};
  endtask
endmodule // uie_host_model
